// *** rafc_pkg.sv ***
package rafc_pkg;
	// register addresses on the serial port
	localparam logic [6:0] ADDR_STATUS = 7'h02;
	localparam logic [6:0] ADDR_MODE1 = 7'h07;
	localparam logic [6:0] ADDR_CTRL2 = 7'h08;
	localparam logic [6:0] ADDR_AFC_CFG = 7'h1d;
	localparam logic [6:0] ADDR_RSSI = 7'h26;
	localparam logic [6:0] ADDR_AFC_LIMIT = 7'h2a;
	localparam logic [6:0] ADDR_AFC_CORR = 7'h2b;
	localparam logic [6:0] ADDR_PH_CFG = 7'h30;
	localparam logic [6:0] ADDR_PRE_THR = 7'h35;
	localparam logic [6:0] ADDR_SYNC1 = 7'h36;
	localparam logic [6:0] ADDR_SYNC0 = 7'h37;
	localparam logic [6:0] ADDR_PKT_LEN = 7'h3e;
	localparam logic [6:0] ADDR_FO1 = 7'h73;
	localparam logic [6:0] ADDR_FO2 = 7'h74;
	localparam logic [6:0] ADDR_BAND = 7'h75;
	localparam logic [6:0] ADDR_FIFO = 7'h7f;
	// field positions
	localparam int BIT_RXON = 2;
	localparam int BIT_PLLON = 1;
	localparam int BIT_MPK = 4;
	localparam int BIT_FFCLR = 1;
	localparam int BIT_AFC_EN = 6;
	localparam int BIT_VCO_SKIP = 0;
	localparam int BIT_PH_EN = 0;
	localparam int BIT_HBSEL = 5;
	// values after reset, and the check-word polynomial
	localparam logic [7:0] RST_MODE1 = 8'h01;
	localparam logic [7:0] RST_CTRL2 = 8'h00;
	localparam logic [7:0] RST_AFC_CFG = 8'h40;
	localparam logic [7:0] RST_AFC_LIMIT = 8'h00;
	localparam logic [7:0] RST_PH_CFG = 8'h00;
	localparam logic [7:0] RST_PRE_THR = 8'h14;
	localparam logic [15:0] RST_SYNC = 16'h2dd4;
	localparam logic [7:0] RST_PKT_LEN = 8'h04;
	localparam logic [9:0] RST_FO = 10'h000;
	localparam logic [7:0] RST_BAND = 8'h35;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	// gain loop thresholds in half-dB signal-strength codes
	localparam logic [7:0] AGC_HIGH = 8'hc8;
	localparam logic [7:0] AGC_LOW = 8'h64;
	localparam logic [3:0] PGA_MAX = 4'h8;
	// receive sequence phases
	typedef enum logic [2:0] {
		RAFC_IDLE,
		RAFC_PREAMBLE,
		RAFC_SYNC,
		RAFC_DATA,
		RAFC_CRC
	} rafc_phase_e;
endpackage

// *** rafc_rx_ctrl.sv ***
`timescale 1ns/1ps
// small valid/ready buffer for received bytes
module rafc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wr;
		logic [AW:0] rd;
	} rafc_fifo_s;
	rafc_fifo_s q, d;
	logic full;
	logic empty;

	// full when pointers differ only in the wrap bit
	assign empty = (q.wr == q.rd);
	assign full = (q.wr[AW-1:0] == q.rd[AW-1:0]) && (q.wr[AW] != q.rd[AW]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = q.mem[q.rd[AW-1:0]];

	// pointer and storage update
	always_comb
	begin
		d = q;
		if (in_valid && !full)
		begin
			d.mem[q.wr[AW-1:0]] = in_data;
			d.wr = q.wr + 1'b1;
		end
		if (out_ready && !empty)
			d.rd = q.rd + 1'b1;
		if (flush)
		begin
			d.wr = '0;
			d.rd = '0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			q <= '0;
		else
			q <= d;
	end
endmodule

// receive control: serial registers, frequency control, packet capture
module rafc_rx_ctrl (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic spi_sclk,
	input wire logic spi_sel_n,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	input wire logic demod_bit,
	input wire logic demod_strobe,
	input wire logic signed [10:0] freq_err,
	input wire logic freq_err_strobe,
	input wire logic [7:0] rssi_code,
	output logic rx_bitstream_output,
	output logic signed [10:0] synth_offset,
	output logic synth_hbsel,
	output logic if_shift_en,
	output logic vco_cal_start,
	output logic [3:0] pga_gain,
	output logic lna_gain_hi,
	output logic [6:0] next_state_sel,
	output logic pkt_valid_evt,
	output logic crc_err_evt,
	output logic preamble_evt
);
	typedef struct packed {
		logic [2:0] sclk_f;
		logic [2:0] sel_f;
		logic [2:0] sdi_f;
		logic sclk_s;
		logic sel_s;
		logic [3:0] cnt;
		logic wr;
		logic [6:0] addr;
		logic [6:0] sh;
		logic [7:0] out;
		logic sdo;
		logic popa;
		logic [7:0] mode1;
		logic [7:0] ctrl2;
		logic [7:0] afc_cfg;
		logic [7:0] afc_lim;
		logic [7:0] ph_cfg;
		logic [7:0] pre_thr;
		logic [15:0] sync;
		logic [7:0] pkt_len;
		logic [9:0] fo;
		logic [7:0] band;
		rafc_pkg::rafc_phase_e phase;
		logic [2:0] bitn;
		logic [7:0] byte_sh;
		logic prev_bit;
		logic [7:0] pre_cnt;
		logic [15:0] pat;
		logic [7:0] pay_cnt;
		logic [4:0] crc_bits;
		logic [15:0] crc;
		logic pend_v;
		logic [7:0] pend;
		logic ovfl;
		logic crc_err;
		logic signed [10:0] corr;
		logic frozen;
		logic [7:0] rssi;
		logic [3:0] pga;
		logic lna_hi;
		logic rxon_p;
		logic synth_p;
		logic vco_cal;
		logic rx_bit;
		logic ev_valid;
		logic ev_crc;
		logic ev_pre;
	} rafc_state_s;
	rafc_state_s q, d;
	logic fifo_ready;
	logic fifo_valid;
	logic [7:0] fifo_data;
	logic fifo_pop;
	logic fifo_flush;
	logic rxon;
	logic afc_en;
	logic signed [12:0] lim;

	assign rxon = q.mode1[rafc_pkg::BIT_RXON];
	assign afc_en = q.afc_cfg[rafc_pkg::BIT_AFC_EN];
	// pull-in limit in 156.25 Hz*(hbsel+1) steps: 625 Hz is four steps
	assign lim = signed'({3'h0, q.afc_lim, 2'h0});

	// register read mux
	function automatic logic [7:0] rd_reg(input logic [6:0] a,
		input rafc_state_s s, input logic fv, input logic [7:0] fd);
		logic [7:0] r;
		r = 8'h00;
		unique case (a)
			rafc_pkg::ADDR_STATUS: r = {4'h0, s.frozen, s.ovfl, s.crc_err,
				fv};
			rafc_pkg::ADDR_MODE1: r = s.mode1;
			rafc_pkg::ADDR_CTRL2: r = s.ctrl2;
			rafc_pkg::ADDR_AFC_CFG: r = s.afc_cfg;
			rafc_pkg::ADDR_RSSI: r = s.rssi;
			rafc_pkg::ADDR_AFC_LIMIT: r = s.afc_lim;
			rafc_pkg::ADDR_AFC_CORR: r = s.corr[10:3];
			rafc_pkg::ADDR_PH_CFG: r = s.ph_cfg;
			rafc_pkg::ADDR_PRE_THR: r = s.pre_thr;
			rafc_pkg::ADDR_SYNC1: r = s.sync[15:8];
			rafc_pkg::ADDR_SYNC0: r = s.sync[7:0];
			rafc_pkg::ADDR_PKT_LEN: r = s.pkt_len;
			rafc_pkg::ADDR_FO1: r = s.fo[7:0];
			rafc_pkg::ADDR_FO2: r = {6'h00, s.fo[9:8]};
			rafc_pkg::ADDR_BAND: r = s.band;
			rafc_pkg::ADDR_FIFO: r = fv ? fd : 8'h00;
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	// next state of the whole block
	always_comb
	begin
		logic sclk_rise;
		logic sclk_fall;
		logic [7:0] full_byte;
		logic [6:0] nxt_addr;
		logic fb;
		logic pkt_end;
		logic signed [12:0] sum;
		logic ov_set;
		d = q;
		sclk_rise = 1'b0;
		sclk_fall = 1'b0;
		fb = 1'b0;
		ov_set = 1'b0;
		fifo_pop = 1'b0;
		fifo_flush = 1'b0;
		pkt_end = 1'b0;
		sum = 13'sh0000;
		full_byte = {q.sh, q.sdi_f[2]};
		nxt_addr = 7'h00;
		d.ev_valid = 1'b0;
		d.ev_crc = 1'b0;
		d.ev_pre = 1'b0;
		d.vco_cal = 1'b0;
		// three-flop pin synchronisers; clock and select taken once the last two agree
		d.sclk_f = {q.sclk_f[1:0], spi_sclk};
		d.sel_f = {q.sel_f[1:0], spi_sel_n};
		d.sdi_f = {q.sdi_f[1:0], spi_sdi};
		if (q.sclk_f[1] == q.sclk_f[2])
			d.sclk_s = q.sclk_f[2];
		if (q.sel_f[1] == q.sel_f[2])
			d.sel_s = q.sel_f[2];
		sclk_rise = d.sclk_s && !q.sclk_s;
		sclk_fall = !d.sclk_s && q.sclk_s;
		// packet receive on demodulated bits
		if (demod_strobe)
			d.rx_bit = demod_bit;
		if (demod_strobe && rxon)
		begin
			d.prev_bit = demod_bit;
			d.pat = {q.pat[14:0], demod_bit};
			unique case (q.phase)
				rafc_pkg::RAFC_IDLE:
					d.phase = rafc_pkg::RAFC_PREAMBLE;
				rafc_pkg::RAFC_PREAMBLE:
				begin
					// alternating bits count toward the threshold
					d.pre_cnt = (demod_bit != q.prev_bit) ? q.pre_cnt + 8'h01
						: 8'h00;
					if (d.pre_cnt >= q.pre_thr)
					begin
						d.phase = rafc_pkg::RAFC_SYNC;
						d.ev_pre = 1'b1;
						d.frozen = afc_en;
					end
				end
				rafc_pkg::RAFC_SYNC:
					if (d.pat == q.sync)
					begin
						d.phase = rafc_pkg::RAFC_DATA;
						d.bitn = 3'h0;
						d.pay_cnt = 8'h00;
						d.crc = rafc_pkg::CRC_INIT;
					end
				rafc_pkg::RAFC_DATA:
				begin
					fb = q.crc[15] ^ demod_bit;
					d.crc = {q.crc[14:0], 1'b0} ^ (fb ? rafc_pkg::CRC_POLY
						: 16'h0000);
					d.byte_sh = {q.byte_sh[6:0], demod_bit};
					d.bitn = q.bitn + 3'h1;
					if (q.bitn == 3'h7)
					begin
						// every byte is payload; overrun if held byte stuck
						ov_set = q.pend_v && !fifo_ready;
						d.ovfl = q.ovfl | ov_set;
						d.pend_v = 1'b1;
						d.pend = d.byte_sh;
						d.pay_cnt = q.pay_cnt + 8'h01;
						if (q.ph_cfg[rafc_pkg::BIT_PH_EN] &&
							d.pay_cnt == q.pkt_len)
						begin
							d.phase = rafc_pkg::RAFC_CRC;
							d.crc_bits = 5'h00;
						end
					end
				end
				rafc_pkg::RAFC_CRC:
				begin
					d.crc_bits = q.crc_bits + 5'h01;
					if (q.crc_bits == 5'h0f)
					begin
						pkt_end = 1'b1;
						d.ev_valid = (d.pat == q.crc);
						d.ev_crc = (d.pat != q.crc);
						d.phase = rafc_pkg::RAFC_PREAMBLE;
						d.pre_cnt = 8'h00;
					end
				end
			endcase
		end
		// packet end releases the freeze; multi-packet starts afresh
		if (pkt_end)
		begin
			d.frozen = 1'b0;
			if (q.ctrl2[rafc_pkg::BIT_MPK])
				d.corr = 11'sh000;
		end
		if (d.ev_crc)
			d.crc_err = 1'b1;
		// good packet without multi-packet leaves receive
		if (d.ev_valid && !q.ctrl2[rafc_pkg::BIT_MPK])
			d.mode1[rafc_pkg::BIT_RXON] = 1'b0;
		// frequency acquisition, clamped to the pull-in limit
		if (afc_en && rxon && !q.frozen && freq_err_strobe)
		begin
			sum = 13'(q.corr) + 13'(freq_err);
			if (sum > lim)
				sum = lim;
			else if (sum < -lim)
				sum = -lim;
			d.corr = sum[10:0];
		end
		// move a held byte into the buffer when it has room
		if (q.pend_v && fifo_ready && !(d.pend_v && !q.pend_v))
			d.pend_v = (q.bitn == 3'h7 && q.phase == rafc_pkg::RAFC_DATA
				&& demod_strobe && rxon);
		// gain loop: 3 dB amplifier steps, one LNA step
		if (demod_strobe && rxon)
		begin
			d.rssi = rssi_code;
			if (rssi_code > rafc_pkg::AGC_HIGH)
			begin
				if (q.pga != 4'h0)
					d.pga = q.pga - 4'h1;
				else
					d.lna_hi = 1'b0;
			end
			else if (rssi_code < rafc_pkg::AGC_LOW)
			begin
				if (!q.lna_hi)
					d.lna_hi = 1'b1;
				else if (q.pga != rafc_pkg::PGA_MAX)
					d.pga = q.pga + 4'h1;
			end
		end
		// serial slave: 1 bit write flag, 7 address bits, data bytes
		if (q.sel_s)
		begin
			d.cnt = 4'h0;
			d.sdo = 1'b0;
			d.popa = 1'b0;
		end
		else if (sclk_rise)
		begin
			d.sh = full_byte[6:0];
			d.cnt = q.cnt + 4'h1;
			// fetched byte leaves the buffer once its first bit is clocked,
			// so a burst that stops there loses no byte
			if (q.cnt == 4'h8)
			begin
				fifo_pop = q.popa;
				d.popa = 1'b0;
			end
			if (q.cnt == 4'h7)
			begin
				d.wr = full_byte[7];
				d.addr = full_byte[6:0];
				if (!full_byte[7])
				begin
					d.out = rd_reg(full_byte[6:0], q, fifo_valid, fifo_data);
					d.popa = fifo_valid &&
						(full_byte[6:0] == rafc_pkg::ADDR_FIFO);
				end
			end
			else if (q.cnt == 4'hf)
			begin
				d.cnt = 4'h8;
				// burst: the buffer address does not advance
				nxt_addr = (q.addr == rafc_pkg::ADDR_FIFO) ? q.addr
					: q.addr + 7'h01;
				d.addr = nxt_addr;
				if (!q.wr)
				begin
					d.out = rd_reg(nxt_addr, q, fifo_valid, fifo_data);
					d.popa = fifo_valid && (nxt_addr == rafc_pkg::ADDR_FIFO);
				end
				else
				begin
					unique case (q.addr)
						rafc_pkg::ADDR_MODE1: d.mode1 = full_byte;
						rafc_pkg::ADDR_CTRL2:
						begin
							d.ctrl2 = full_byte;
							fifo_flush = full_byte[rafc_pkg::BIT_FFCLR];
						end
						rafc_pkg::ADDR_AFC_CFG: d.afc_cfg = full_byte;
						rafc_pkg::ADDR_AFC_LIMIT: d.afc_lim = full_byte;
						rafc_pkg::ADDR_PH_CFG: d.ph_cfg = full_byte;
						rafc_pkg::ADDR_PRE_THR: d.pre_thr = full_byte;
						rafc_pkg::ADDR_SYNC1: d.sync[15:8] = full_byte;
						rafc_pkg::ADDR_SYNC0: d.sync[7:0] = full_byte;
						rafc_pkg::ADDR_PKT_LEN: d.pkt_len = full_byte;
						rafc_pkg::ADDR_FO1: d.fo[7:0] = full_byte;
						rafc_pkg::ADDR_FO2: d.fo[9:8] = full_byte[1:0];
						rafc_pkg::ADDR_BAND: d.band = full_byte;
						rafc_pkg::ADDR_STATUS:
						begin
							// write one to clear, a new event still wins
							d.crc_err = d.crc_err & !(full_byte[1] && !d.ev_crc);
							d.ovfl = d.ovfl & !(full_byte[2] && !ov_set);
						end
						default: d.band = q.band;
					endcase
				end
			end
		end
		else if (sclk_fall && q.cnt >= 4'h8 && !q.wr)
		begin
			d.sdo = q.out[7];
			d.out = {q.out[6:0], 1'b0};
		end
		// entering receive: release freeze, restart acquisition
		d.rxon_p = rxon;
		if (rxon && !q.rxon_p)
		begin
			d.corr = 11'sh000;
			d.frozen = 1'b0;
			d.phase = rafc_pkg::RAFC_PREAMBLE;
			d.pre_cnt = 8'h00;
		end
		if (!rxon)
			d.phase = rafc_pkg::RAFC_IDLE;
		// calibrate the VCO bank on every synthesizer enable unless the skip bit in afc_cfg is set
		d.synth_p = q.mode1[rafc_pkg::BIT_PLLON] | rxon;
		d.vco_cal = d.synth_p && !q.synth_p &&
			!q.afc_cfg[rafc_pkg::BIT_VCO_SKIP];
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			q <= '0;
			q.sclk_f <= 3'h0;
			q.sel_f <= 3'h7;
			q.sel_s <= 1'b1;
			q.mode1 <= rafc_pkg::RST_MODE1;
			q.ctrl2 <= rafc_pkg::RST_CTRL2;
			q.afc_cfg <= rafc_pkg::RST_AFC_CFG;
			q.afc_lim <= rafc_pkg::RST_AFC_LIMIT;
			q.ph_cfg <= rafc_pkg::RST_PH_CFG;
			q.pre_thr <= rafc_pkg::RST_PRE_THR;
			q.sync <= rafc_pkg::RST_SYNC;
			q.pkt_len <= rafc_pkg::RST_PKT_LEN;
			q.fo <= rafc_pkg::RST_FO;
			q.band <= rafc_pkg::RST_BAND;
			q.phase <= rafc_pkg::RAFC_IDLE;
			q.crc <= rafc_pkg::CRC_INIT;
		end
		else
			q <= d;
	end

	rafc_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.flush(fifo_flush),
		.in_valid(q.pend_v),
		.in_ready(fifo_ready),
		.in_data(q.pend),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	// one shared offset path: automatic or manual, never both
	assign synth_offset = afc_en ? q.corr : {q.fo[9], q.fo};
	assign synth_hbsel = q.band[rafc_pkg::BIT_HBSEL];
	assign if_shift_en = rxon;
	assign vco_cal_start = q.vco_cal;
	assign pga_gain = q.pga;
	assign lna_gain_hi = q.lna_hi;
	assign next_state_sel = {q.mode1[7:3], q.mode1[1:0]};
	assign rx_bitstream_output = q.rx_bit;
	assign pkt_valid_evt = q.ev_valid;
	assign crc_err_evt = q.ev_crc;
	assign preamble_evt = q.ev_pre;
	assign spi_sdo = q.sdo;
	assign spi_sdo_oe = !q.sel_s;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_good_end;
		$rose(q.ev_valid);
	endsequence
	sequence s_rx_entry;
		$rose(rxon);
	endsequence

	property p_freeze_hold;
		q.frozen && $stable(q.frozen) |-> $stable(q.corr);
	endproperty
	a_freeze_hold: assert property (p_freeze_hold)
		else $error("correction moved while frozen");

	property p_limit;
		13'(q.corr) <= lim && 13'(q.corr) >= -lim;
	endproperty
	a_limit: assert property (p_limit)
		else $error("correction beyond pull-in limit");

	property p_leave_rx;
		s_good_end and !q.ctrl2[rafc_pkg::BIT_MPK]
			and $past(q.sel_s) |-> !rxon;
	endproperty
	a_leave_rx: assert property (p_leave_rx)
		else $error("receive not left after good packet");

	property p_mpk_reset;
		$rose(q.ev_valid | q.ev_crc) && q.ctrl2[rafc_pkg::BIT_MPK]
			&& afc_en |-> q.corr == 11'sh000 && !q.frozen;
	endproperty
	a_mpk_reset: assert property (p_mpk_reset)
		else $error("correction not reset at packet end");

	property p_sync_order;
		q.phase == rafc_pkg::RAFC_DATA &&
			$past(q.phase) != rafc_pkg::RAFC_DATA |->
			$past(q.phase) == rafc_pkg::RAFC_SYNC;
	endproperty
	a_sync_order: assert property (p_sync_order)
		else $error("data phase without sync after preamble");

	property p_fill_gate;
		$rose(q.pend_v) |-> $past(q.phase) == rafc_pkg::RAFC_DATA;
	endproperty
	a_fill_gate: assert property (p_fill_gate)
		else $error("byte stored outside payload");

	property p_reentry;
		s_rx_entry |=> q.corr == 11'sh000 && !q.frozen;
	endproperty
	a_reentry: assert property (p_reentry)
		else $error("stale correction on receive entry");

	property p_vco;
		$rose(q.mode1[rafc_pkg::BIT_PLLON] | rxon) &&
			!q.afc_cfg[rafc_pkg::BIT_VCO_SKIP] |=> vco_cal_start ##1
			!vco_cal_start;
	endproperty
	a_vco: assert property (p_vco)
		else $error("VCO calibration pulse missing");

	property p_manual;
		!afc_en |-> synth_offset[9:0] == q.fo && synth_offset[10] == q.fo[9];
	endproperty
	a_manual: assert property (p_manual)
		else $error("manual offset not applied");
endmodule

// *** rafc_spi_host.sv ***
`timescale 1ns/1ps
// controller model: mode 0 frames on a free-phase 160 ns link clock
module rafc_spi_host (
	output logic spi_sclk,
	output logic spi_sel_n,
	output logic spi_sdi,
	input wire logic spi_sdo,
	input wire logic spi_sdo_oe,
	output logic rd_stb,
	output logic [7:0] rd_byte
);
	logic last_q;
	initial
	begin
		spi_sclk = 1'b0;
		spi_sel_n = 1'b1;
		spi_sdi = 1'b0;
		rd_stb = 1'b0;
		rd_byte = 8'h00;
		last_q = 1'b0;
	end
	// data line wanders outside frames so no stale level is relied on
	always #37
		if (spi_sel_n)
			spi_sdi = ~spi_sdi;
	// one byte each way, msb first; a released sdo reads as the previous bit inverted
	task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			spi_sdi = tx[i];
			#110 spi_sclk = 1'b1;
			last_q = spi_sdo_oe ? spi_sdo : ~last_q;
			rx[i] = last_q;
			#50 spi_sclk = 1'b0;
		end
	endtask
	// command byte then n data bytes; each read byte pulses rd_stb
	task automatic frame(input logic wr, input logic [6:0] a, input int n,
		input logic [31:0] wd);
		logic [7:0] rx;
		spi_sel_n = 1'b0;
		#100;
		shift({wr, a}, rx);
		for (int k = 0; k < n; k++)
		begin
			shift(wd[31-8*k -: 8], rx);
			if (!wr)
			begin
				rd_byte = rx;
				rd_stb = 1'b1;
				#20 rd_stb = 1'b0;
			end
		end
		#110 spi_sel_n = 1'b1;
		#200;
	endtask
endmodule

// *** rafc_rx_ctrl_test.sv ***
`timescale 1ns/1ps
module rafc_rx_ctrl_test;
	typedef struct packed {logic [7:0] v; logic [7:0] m;} rafc_exp_s;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic demod_bit = 1'b0;
	logic demod_strobe = 1'b0;
	logic signed [10:0] freq_err = 11'sd0;
	logic freq_err_strobe = 1'b0;
	logic [7:0] rssi_code = 8'h00;
	logic spi_sclk, spi_sel_n, spi_sdi, spi_sdo, spi_sdo_oe, rd_stb;
	logic [7:0] rd_byte, last_rssi;
	logic rx_bitstream_output, synth_hbsel, if_shift_en, vco_cal_start;
	logic signed [10:0] synth_offset, frz;
	logic [3:0] pga_gain;
	logic lna_gain_hi, pkt_valid_evt, crc_err_evt, preamble_evt;
	logic [6:0] next_state_sel;
	logic [31:0] seed = 32'd32897;
	logic [2:0] ev;
	rafc_exp_s re;
	rafc_exp_s rd_q[$];
	logic [2:0] ev_q[$];
	int num_errors = 0;
	int num_checks = 0;
	int vco_cnt = 0;
	int n, cnt;
	always #10 clk_sys = ~clk_sys;
	rafc_rx_ctrl u_dut (.clk_sys(clk_sys), .rst(rst), .spi_sclk(spi_sclk),
		.spi_sel_n(spi_sel_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
		.spi_sdo_oe(spi_sdo_oe), .demod_bit(demod_bit),
		.demod_strobe(demod_strobe), .freq_err(freq_err),
		.freq_err_strobe(freq_err_strobe), .rssi_code(rssi_code),
		.rx_bitstream_output(rx_bitstream_output),
		.synth_offset(synth_offset), .synth_hbsel(synth_hbsel),
		.if_shift_en(if_shift_en), .vco_cal_start(vco_cal_start),
		.pga_gain(pga_gain), .lna_gain_hi(lna_gain_hi),
		.next_state_sel(next_state_sel), .pkt_valid_evt(pkt_valid_evt),
		.crc_err_evt(crc_err_evt), .preamble_evt(preamble_evt));
	rafc_spi_host u_host (.spi_sclk(spi_sclk), .spi_sel_n(spi_sel_n),
		.spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
		.rd_stb(rd_stb), .rd_byte(rd_byte));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? rafc_pkg::CRC_POLY : 16'h0);
		return c;
	endfunction
	function automatic logic [10:0] mag(input logic signed [10:0] v);
		return (v < 0) ? 11'(-v) : 11'(v);
	endfunction
	task automatic cmp(input string nm, input logic [15:0] e,
		input logic [15:0] s);
		num_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tick();
		@(posedge clk_sys);
		#2;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		u_host.frame(1'b1, a, 1, {d, 24'h0});
	endtask
	// note n expected bytes (right aligned in e), then read them in a burst
	task automatic rd(input logic [6:0] a, input int n, input logic [31:0] e,
		input logic [7:0] m);
		for (int k = 0; k < n; k++)
			rd_q.push_back({e[8*(n-1-k) +: 8], m});
		u_host.frame(1'b0, a, n, 32'h0);
	endtask
	// demodulated bits msb first with fresh strength codes
	task automatic bits(input logic [31:0] v, input int nb);
		for (int i = nb - 1; i >= 0; i--)
		begin
			tick();
			demod_bit = v[i];
			demod_strobe = 1'b1;
			seed = xs(seed);
			rssi_code = seed[7:0];
			last_rssi = seed[7:0];
			tick();
			demod_strobe = 1'b0;
			tick();
			cmp("bitstream", 16'(v[i]), 16'(rx_bitstream_output));
		end
	endtask
	task automatic ferr(input logic signed [10:0] v, input int k);
		repeat (k)
		begin
			tick();
			freq_err = v;
			freq_err_strobe = 1'b1;
			tick();
			freq_err_strobe = 1'b0;
		end
		repeat (3) tick();
	endtask
	// preamble, sync, payload, then check word when the handler is on
	task automatic packet(input logic [47:0] p, input int nb,
		input logic good, input logic ph);
		logic [15:0] c;
		c = rafc_pkg::CRC_INIT;
		bits(32'h55555555, 32);
		bits(32'h55, 8);
		frz = synth_offset;
		ferr(-11'sd300, 3);
		cmp("frozen", 16'(frz), 16'(synth_offset));
		bits(32'(rafc_pkg::RST_SYNC), 16);
		for (int k = nb - 1; k >= 0; k--)
		begin
			bits(32'(p[8*k +: 8]), 8);
			c = crc_byte(c, p[8*k +: 8]);
		end
		if (ph)
			bits(32'(good ? c : ~c), 16);
		repeat (6) tick();
	endtask
	// read results and event pulses against the oldest note
	always @(posedge rd_stb)
	begin
		re = rd_q.size() ? rd_q.pop_front() : 16'h00ff;
		cmp("read", 16'(re.v & re.m), 16'(rd_byte & re.m));
	end
	// pulses looked at mid-cycle, clear of the edge that launches them
	always @(negedge clk_sys)
		if (pkt_valid_evt || crc_err_evt || preamble_evt)
		begin
			ev = ev_q.size() ? ev_q.pop_front() : 3'h0;
			cmp("event", 16'(ev), 16'({pkt_valid_evt, crc_err_evt,
				preamble_evt}));
		end
	always @(negedge clk_sys)
		if (vco_cal_start === 1'b1)
			vco_cnt++;
	// watchdog
	initial
	begin
		#1000000;
		num_errors++;
		final_report();
	end
	initial
	begin
		repeat (8) @(posedge clk_sys);
		#2 rst = 1'b0;
		repeat (6) tick();
		rd(rafc_pkg::ADDR_AFC_LIMIT, 1, 32'h0, 8'hff);
		wr(rafc_pkg::ADDR_AFC_LIMIT, 8'h05);
		rd(rafc_pkg::ADDR_AFC_LIMIT, 1, 32'h05, 8'hff);
		rd(7'h50, 1, 32'h0, 8'hff);
		wr(rafc_pkg::ADDR_FIFO, 8'ha5);
		rd(rafc_pkg::ADDR_FIFO, 1, 32'h0, 8'hff);
		cmp("hbsel", 16'h1, 16'(synth_hbsel));
		cmp("next_state", 16'h1, 16'(next_state_sel));
		$display("test registers done");
		wr(rafc_pkg::ADDR_PRE_THR, 8'h14);
		wr(rafc_pkg::ADDR_SYNC1, 8'h2d);
		wr(rafc_pkg::ADDR_SYNC0, 8'hd4);
		wr(rafc_pkg::ADDR_PKT_LEN, 8'h02);
		wr(rafc_pkg::ADDR_PH_CFG, 8'h01);
		wr(rafc_pkg::ADDR_CTRL2, 8'h10);
		n = vco_cnt;
		wr(rafc_pkg::ADDR_MODE1, 8'h07);
		cmp("vco_cal", 16'(n + 1), 16'(vco_cnt));
		cmp("if_shift", 16'h1, 16'(if_shift_en));
		ferr(11'sd300, 4);
		cmp("afc_clamp", 16'd20, 16'(mag(synth_offset)));
		ev_q = '{3'b001, 3'b100, 3'b001, 3'b010};
		packet(48'h3ca7, 2, 1'b1, 1'b1);
		cmp("afc_clear", 16'h0, 16'(synth_offset));
		rd(rafc_pkg::ADDR_MODE1, 1, 32'h07, 8'hff);
		rd(rafc_pkg::ADDR_FIFO, 2, 32'h3ca7, 8'hff);
		ferr(11'sd300, 4);
		cmp("afc_again", 16'd20, 16'(mag(synth_offset)));
		packet(48'h5a0f, 2, 1'b0, 1'b1);
		rd(rafc_pkg::ADDR_STATUS, 1, 32'h02, 8'h02);
		wr(rafc_pkg::ADDR_STATUS, 8'h02);
		rd(rafc_pkg::ADDR_STATUS, 1, 32'h00, 8'h02);
		wr(rafc_pkg::ADDR_CTRL2, 8'h02);
		wr(rafc_pkg::ADDR_CTRL2, 8'h00);
		wr(rafc_pkg::ADDR_MODE1, 8'h07);
		ev_q = '{3'b001, 3'b100};
		packet(48'he681, 2, 1'b1, 1'b1);
		rd(rafc_pkg::ADDR_MODE1, 1, 32'h03, 8'hff);
		cmp("next_state", 16'h3, 16'(next_state_sel));
		cmp("if_shift", 16'h0, 16'(if_shift_en));
		rd(rafc_pkg::ADDR_RSSI, 1, 32'(last_rssi), 8'hff);
		rd(rafc_pkg::ADDR_FIFO, 2, 32'he681, 8'hff);
		$display("test handler packets done");
		wr(rafc_pkg::ADDR_PH_CFG, 8'h00);
		wr(rafc_pkg::ADDR_MODE1, 8'h07);
		bits(32'(rafc_pkg::RST_SYNC), 16);
		bits(32'h81, 8);
		rd(rafc_pkg::ADDR_STATUS, 1, 32'h00, 8'h01);
		ev_q = '{3'b001};
		packet(48'h112233445566, 6, 1'b1, 1'b0);
		rd(rafc_pkg::ADDR_STATUS, 1, 32'h05, 8'h05);
		rd(rafc_pkg::ADDR_FIFO, 3, 32'h112233, 8'hff);
		$display("test raw stream done");
		// overrun kept the first four bytes; the held byte was overwritten
		rd(rafc_pkg::ADDR_FIFO, 2, 32'h4466, 8'hff);
		rd(rafc_pkg::ADDR_STATUS, 1, 32'h04, 8'h05);
		wr(rafc_pkg::ADDR_STATUS, 8'h04);
		cmp("sdo_release", 16'h0, 16'(spi_sdo_oe));
		seed = xs(seed);
		cnt = int'(seed[15:0]);
		bits(32'(cnt), 16);
		rd(rafc_pkg::ADDR_STATUS, 1, 32'h01, 8'h05);
		rd(rafc_pkg::ADDR_FIFO, 2, 32'(cnt), 8'hff);
		$display("test buffer done");
		wr(rafc_pkg::ADDR_MODE1, 8'h03);
		wr(rafc_pkg::ADDR_AFC_CFG, 8'h01);
		wr(rafc_pkg::ADDR_FO1, 8'h34);
		wr(rafc_pkg::ADDR_FO2, 8'h03);
		cmp("manual_offset", 16'hff34, 16'(synth_offset));
		wr(rafc_pkg::ADDR_BAND, 8'h15);
		cmp("hbsel", 16'h0, 16'(synth_hbsel));
		n = vco_cnt;
		wr(rafc_pkg::ADDR_MODE1, 8'h01);
		wr(rafc_pkg::ADDR_MODE1, 8'h03);
		cmp("vco_skip", 16'(n), 16'(vco_cnt));
		cmp("pga_range", 16'h1, 16'(pga_gain <= rafc_pkg::PGA_MAX));
		$display("test manual offset done");
		cmp("pending", 16'h0, 16'(rd_q.size() + ev_q.size()));
		final_report();
	end
endmodule
